// File: hw/bit_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
// Assumes: inputs are slow levels; the first stage is read only by the second.
`timescale 1ns/1ns
`default_nettype none

module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // First stage, may go metastable.
   logic [WIDTH-1:0] meta;

   // ==========
   // Both stages reset high, matching an open contact on an active-low pin.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '1;
         dout <= '1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : bit_sync

`default_nettype wire

// File: hw/current_loop_output_select.sv
// Target value selector for a 4 to 20 mA current-loop output driven from temperature.
// Assumes: APB slave with zero wait states; temperature samples come from logic on CLK_SYS;
// the hold contact arrives on an asynchronous pin, low while the contact to ground is closed.
// Functional notes
// - Rising or inverted output direction selectable.
// - Digital input function: inactive or hold.
// - Hold active while contact to ground closed.
// - Hold output: low, high, frozen, substitute.
// - Fault output: low, high, NAMUR, frozen, substitute.
// - Substitute value limited to 3.6-22 mA.
// - Scale start temperature maps to 4 mA, or to 20 mA when inverted.
// - Scale end temperature maps to 20 mA, or to 4 mA when inverted.
// - Add offset correction before scaling.
`timescale 1ns/1ns
`default_nettype none

module current_loop_output_select (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic TEMP_VALID,
   input wire logic signed [15:0] TEMP_DATA,
   output logic TEMP_READY,
   input wire logic FAULT,
   input wire logic HOLD_CONTACT_N,
   output logic [15:0] LOOP_UA,
   output logic IRQ
);

   // ==========
   // Clamp helper, used for every signed configuration write.
   function automatic logic signed [15:0] clamp_s16(input logic signed [15:0] v,
                                                    input logic signed [15:0] lo,
                                                    input logic signed [15:0] hi);
      logic signed [15:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction : clamp_s16

   // ==========
   // Configuration and status storage.
   logic [11:0] ctrl; // Direction, input function and responses.
   logic signed [15:0] subst; // Substitute current in microamps.
   logic signed [15:0] t_start; // Scale start in tenths of a degree.
   logic signed [15:0] t_end; // Scale end in tenths of a degree.
   logic signed [15:0] offset; // Correction in tenths of a degree.
   logic [loop_out_pkg::EV_NUM-1:0] status; // Sticky event bits.
   logic [loop_out_pkg::EV_NUM-1:0] int_en; // Interrupt enables.

   // Conversion sequencer states.
   typedef enum logic [1:0] {S_IDLE, S_EVAL, S_DIV} conv_state_t;
   conv_state_t state;

   logic signed [16:0] corr; // Corrected temperature of the sample in flight.
   logic signed [15:0] lin_ua; // Linear output for the latest sample.
   logic signed [15:0] frozen_ua; // Last output before hold or fault.
   logic contact_n_sync; // Synchronised contact level.
   logic hold_q; // Hold state of the previous cycle.
   logic fault_q; // Fault state of the previous cycle.

   div_if dvi ();

   // ==========
   // The contact is an asynchronous pin and passes two flops first.
   bit_sync #(.WIDTH(1)) u_sync (
      .clk(CLK_SYS),
      .rst_n(RSTN),
      .din(HOLD_CONTACT_N),
      .dout(contact_n_sync)
   );

   seq_divider u_div (
      .clk(CLK_SYS),
      .rst_n(RSTN),
      .dv(dvi)
   );

   // ==========
   // APB decode; zero wait states, so every access completes in its first access cycle.
   wire setup = PSEL && !PENABLE;
   wire wr = PSEL && PENABLE && PWRITE;
   wire sel_ctrl = (PADDR == loop_out_pkg::ADDR_CTRL);
   wire sel_subst = (PADDR == loop_out_pkg::ADDR_SUBST);
   wire sel_start = (PADDR == loop_out_pkg::ADDR_START);
   wire sel_end = (PADDR == loop_out_pkg::ADDR_END);
   wire sel_offset = (PADDR == loop_out_pkg::ADDR_OFFSET);
   wire sel_status = (PADDR == loop_out_pkg::ADDR_STATUS);
   wire sel_int_en = (PADDR == loop_out_pkg::ADDR_INT_EN);
   wire sel_int_clr = (PADDR == loop_out_pkg::ADDR_INT_CLR);
   wire sel_output = (PADDR == loop_out_pkg::ADDR_OUTPUT);
   wire sel_temp = (PADDR == loop_out_pkg::ADDR_TEMP);
   wire mapped = sel_ctrl | sel_subst | sel_start | sel_end | sel_offset | sel_status | sel_int_en
                 | sel_int_clr | sel_output | sel_temp;

   // Every register answers at once, so ready never needs to drop.
   assign PREADY = 1'b1;
   // Unmapped addresses complete with an error and change nothing.
   assign PSLVERR = PSEL && PENABLE && !mapped;

   // Write values, limited to their legal ranges.
   wire signed [15:0] wdata16 = PWDATA[15:0];
   wire signed [15:0] subst_w = clamp_s16(wdata16, loop_out_pkg::UA_NAMUR_LOW,
                                          loop_out_pkg::UA_NAMUR_HIGH);
   wire signed [15:0] start_w = clamp_s16(wdata16, loop_out_pkg::TEMP_MIN,
      loop_out_pkg::TEMP_MAX);
   wire signed [15:0] end_w = clamp_s16(wdata16, loop_out_pkg::TEMP_MIN,
      loop_out_pkg::TEMP_MAX);
   wire signed [15:0] offset_w = clamp_s16(wdata16, loop_out_pkg::OFFS_MIN,
      loop_out_pkg::OFFS_MAX);
   // A write that had to be limited raises an event so software sees it.
   wire clamp_hit = wr && ((sel_subst && subst_w != wdata16) || (sel_start && start_w != wdata16)
                    || (sel_end && end_w != wdata16) || (sel_offset && offset_w != wdata16));

   // ==========
   // Configuration writes; ctrl keeps only its defined fields.
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ctrl <= loop_out_pkg::RST_CTRL;
         subst <= loop_out_pkg::RST_SUBST;
         t_start <= loop_out_pkg::RST_START;
         t_end <= loop_out_pkg::RST_END;
         offset <= loop_out_pkg::RST_OFFSET;
         int_en <= '0;
      end else if (wr) begin
         if (sel_ctrl) begin
            ctrl <= PWDATA[11:0] & 12'h733;
         end
         if (sel_subst) begin
            subst <= subst_w;
         end
         if (sel_start) begin
            t_start <= start_w;
         end
         if (sel_end) begin
            t_end <= end_w;
         end
         if (sel_offset) begin
            offset <= offset_w;
         end
         if (sel_int_en) begin
            int_en <= PWDATA[loop_out_pkg::EV_NUM-1:0];
         end
      end
   end

   // ==========
   // Control fields.
   wire invert = ctrl[loop_out_pkg::CTRL_INV_BIT];
   wire di_hold = ctrl[loop_out_pkg::CTRL_DI_BIT];
   wire [1:0] hold_sel = ctrl[loop_out_pkg::CTRL_HOLD_LSB +: 2];
   wire [2:0] fault_sel = ctrl[loop_out_pkg::CTRL_FAULT_LSB +: 3];

   // Hold needs the input set to hold and the contact closed (pin low).
   wire contact_closed = !contact_n_sync;
   wire hold_act = di_hold && contact_closed;

   // ==========
   // Scaling arithmetic on the corrected sample.
   wire signed [16:0] next_corr = {TEMP_DATA[15], TEMP_DATA} + {offset[15], offset};
   wire signed [17:0] num_raw = {corr[16], corr} - {{2{t_start[15]}}, t_start};
   wire signed [16:0] den_raw = {t_end[15], t_end} - {t_start[15], t_start};
   // A falling span is normalised so the divider only sees positive numbers.
   wire signed [17:0] num_adj = den_raw[16] ? -num_raw : num_raw;
   wire signed [16:0] den_abs = den_raw[16] ? -den_raw : den_raw;
   wire frac_zero = (den_abs == 17'sd0) || (num_adj <= 18'sd0);
   wire frac_full = (num_adj >= {den_abs[16], den_abs});
   assign dvi.dividend = 27'(num_adj[10:0]) * 27'(loop_out_pkg::UA_SPAN);
   assign dvi.divisor = den_abs[11:0];
   assign dvi.start = (state == S_EVAL) && !frac_zero && !frac_full;
   assign TEMP_READY = (state == S_IDLE);

   // Fraction of the span in microamps, from the trivial cases or the divider.
   wire [13:0] frac_ua = frac_zero ? 14'h0000
      : (frac_full ? loop_out_pkg::UA_SPAN : dvi.quotient[13:0]);
   // Rising adds to the low end, inverted subtracts from the high end.
   wire signed [15:0] next_lin = invert ? (loop_out_pkg::UA_HIGH - 16'(frac_ua))
                                        : (loop_out_pkg::UA_LOW + 16'(frac_ua));
   wire lin_load = ((state == S_EVAL) && (frac_zero || frac_full))
      || ((state == S_DIV) && dvi.done);

   // ==========
   // Sequencer: take a sample, check the easy cases, else divide.
   // Samples offered while busy are refused through TEMP_READY, so none is half used.
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         state <= S_IDLE;
         corr <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               if (TEMP_VALID) begin
                  corr <= next_corr;
                  state <= S_EVAL;
               end
            end
            S_EVAL: begin
               state <= (frac_zero || frac_full) ? S_IDLE : S_DIV;
            end
            S_DIV: begin
               if (dvi.done) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Linear result register, updated once per finished sample.
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         lin_ua <= loop_out_pkg::UA_LOW;
      end else if (lin_load) begin
         lin_ua <= next_lin;
      end
   end

   // ==========
   // Output selection; a fault outranks hold so alarm levels are never masked.
   logic signed [15:0] next_out;
   always_comb begin
      next_out = lin_ua;
      if (FAULT) begin
         case (fault_sel)
            loop_out_pkg::FLT_LOW: next_out = loop_out_pkg::UA_LOW;
            loop_out_pkg::FLT_HIGH: next_out = loop_out_pkg::UA_HIGH;
            loop_out_pkg::FLT_NAMUR_LOW: next_out = loop_out_pkg::UA_NAMUR_LOW;
            loop_out_pkg::FLT_NAMUR_HIGH: next_out = loop_out_pkg::UA_NAMUR_HIGH;
            loop_out_pkg::FLT_FROZEN: next_out = frozen_ua;
            loop_out_pkg::FLT_SUBST: next_out = subst;
            default: next_out = frozen_ua;
         endcase
      end else if (hold_act) begin
         case (hold_sel)
            loop_out_pkg::HOLD_LOW: next_out = loop_out_pkg::UA_LOW;
            loop_out_pkg::HOLD_HIGH: next_out = loop_out_pkg::UA_HIGH;
            loop_out_pkg::HOLD_FROZEN: next_out = frozen_ua;
            loop_out_pkg::HOLD_SUBST: next_out = subst;
            default: next_out = frozen_ua;
         endcase
      end
   end

   // Output register and frozen copy; the copy only follows in normal operation.
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         LOOP_UA <= loop_out_pkg::UA_LOW;
         frozen_ua <= loop_out_pkg::UA_LOW;
         hold_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         LOOP_UA <= next_out;
         hold_q <= hold_act;
         fault_q <= FAULT;
         if (!hold_act && !FAULT) begin
            frozen_ua <= lin_ua;
         end
      end
   end

   // ==========
   // Events, sticky status with write-one-to-clear; a set in the clear cycle wins.
   logic [loop_out_pkg::EV_NUM-1:0] ev_set;
   always_comb begin
      ev_set = '0;
      ev_set[loop_out_pkg::EV_SAMPLE] = lin_load;
      ev_set[loop_out_pkg::EV_HOLD_ON] = hold_act && !hold_q;
      ev_set[loop_out_pkg::EV_HOLD_OFF] = !hold_act && hold_q;
      ev_set[loop_out_pkg::EV_FAULT_ON] = FAULT && !fault_q;
      ev_set[loop_out_pkg::EV_FAULT_OFF] = !FAULT && fault_q;
      ev_set[loop_out_pkg::EV_CLAMP] = clamp_hit;
   end
   wire [loop_out_pkg::EV_NUM-1:0] ev_clr = (wr && sel_int_clr)
      ? PWDATA[loop_out_pkg::EV_NUM-1:0] : '0;

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         status <= '0;
      end else begin
         status <= (status & ~ev_clr) | ev_set;
      end
   end

   // Level interrupt, high while any enabled event is still pending.
   assign IRQ = |(status & int_en);

   // ==========
   // Read data is captured in the setup cycle, so it stands through the access cycle.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_mux = {20'h0_0000, ctrl};
      end else if (sel_subst) begin
         rd_mux = {{16{subst[15]}}, subst};
      end else if (sel_start) begin
         rd_mux = {{16{t_start[15]}}, t_start};
      end else if (sel_end) begin
         rd_mux = {{16{t_end[15]}}, t_end};
      end else if (sel_offset) begin
         rd_mux = {{16{offset[15]}}, offset};
      end else if (sel_status) begin
         rd_mux = {26'h000_0000, status};
      end else if (sel_int_en) begin
         rd_mux = {26'h000_0000, int_en};
      end else if (sel_output) begin
         rd_mux = {13'h0000, contact_closed, FAULT, hold_act, LOOP_UA};
      end else if (sel_temp) begin
         rd_mux = {{15{corr[16]}}, corr};
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         PRDATA <= rd_mux;
      end
   end

endmodule : current_loop_output_select

`default_nettype wire

// File: hw/seq_divider.sv
// Restoring unsigned divider, one quotient bit per clock.
// Assumes: the master holds dividend and divisor steady and never divides by zero.
`timescale 1ns/1ns
`default_nettype none

module seq_divider (
   input wire logic clk,
   input wire logic rst_n,
   div_if.slave dv
);
   localparam int NW = loop_out_pkg::DIV_NW;
   localparam int DW = loop_out_pkg::DIV_DW;

   logic [DW:0] rem; // Partial remainder, always below the divisor.
   logic [NW-1:0] quo; // Dividend shifting out, quotient shifting in.
   logic [5:0] cnt; // Bits still to produce.
   logic [DW:0] shifted; // Remainder with the next dividend bit.
   logic [DW:0] diff; // Trial subtraction.

   assign shifted = {rem[DW-1:0], quo[NW-1]};
   assign diff = shifted - {1'b0, dv.divisor};
   assign dv.busy = (cnt != 6'h00);
   assign dv.quotient = quo;

   // ==========
   // Load on start, then one restoring step per cycle; done pulses on the last.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rem <= '0;
         quo <= '0;
         cnt <= 6'h00;
         dv.done <= 1'b0;
      end else begin
         dv.done <= (cnt == 6'h01);
         if (dv.start && !dv.busy) begin
            rem <= '0;
            quo <= dv.dividend;
            cnt <= 6'(NW);
         end else if (dv.busy) begin
            // A negative trial keeps the remainder and shifts in a zero.
            rem <= diff[DW] ? shifted : diff;
            quo <= {quo[NW-2:0], ~diff[DW]};
            cnt <= cnt - 6'h01;
         end
      end
   end
endmodule : seq_divider

`default_nettype wire

// File: include/div_if.sv
// Interface between the scaling logic and its sequential divider.
// Assumes: one clock domain; start is a one-cycle pulse while busy is low.
`timescale 1ns/1ns
`default_nettype none

interface div_if;
   logic start; // One-cycle request.
   logic [loop_out_pkg::DIV_NW-1:0] dividend; // Held stable while busy.
   logic [loop_out_pkg::DIV_DW-1:0] divisor; // Held stable while busy, never zero.
   logic busy; // High while dividing.
   logic done; // One-cycle pulse with the quotient valid.
   logic [loop_out_pkg::DIV_NW-1:0] quotient; // Result, stands until next start.
   modport master (output start, output dividend, output divisor, input busy, input done, input quotient);
   modport slave (input start, input dividend, input divisor, output busy, output done, output quotient);
endinterface : div_if

`default_nettype wire

// File: include/loop_out_pkg.sv
// Package of constants and types for the current-loop output selector.
// Assumes: included before the interface and the design modules; APB byte addresses.

package loop_out_pkg;

   // ==========
   // Register byte addresses on the APB side.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SUBST = 8'h04;
   localparam logic [7:0] ADDR_START = 8'h08;
   localparam logic [7:0] ADDR_END = 8'h0C;
   localparam logic [7:0] ADDR_OFFSET = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_INT_EN = 8'h18;
   localparam logic [7:0] ADDR_INT_CLR = 8'h1C;
   localparam logic [7:0] ADDR_OUTPUT = 8'h20;
   localparam logic [7:0] ADDR_TEMP = 8'h24;

   // ==========
   // Control and output register field positions.
   localparam int CTRL_INV_BIT = 0;
   localparam int CTRL_DI_BIT = 1;
   localparam int CTRL_HOLD_LSB = 4;
   localparam int CTRL_FAULT_LSB = 8;
   localparam int OUT_HOLD_BIT = 16;
   localparam int OUT_FAULT_BIT = 17;
   localparam int OUT_CONTACT_BIT = 18;

   // ==========
   // Event bit positions, shared by status, enable and clear.
   localparam int EV_SAMPLE = 0;
   localparam int EV_HOLD_ON = 1;
   localparam int EV_HOLD_OFF = 2;
   localparam int EV_FAULT_ON = 3;
   localparam int EV_FAULT_OFF = 4;
   localparam int EV_CLAMP = 5;
   localparam int EV_NUM = 6;

   // ==========
   // Loop currents in microamps, temperatures in tenths of a degree Celsius.
   localparam logic signed [15:0] UA_LOW = 16'sh0FA0;
   localparam logic signed [15:0] UA_HIGH = 16'sh4E20;
   localparam logic signed [15:0] UA_NAMUR_LOW = 16'sh0E10;
   localparam logic signed [15:0] UA_NAMUR_HIGH = 16'sh55F0;
   localparam logic [13:0] UA_SPAN = 14'h3E80;
   localparam logic signed [15:0] TEMP_MIN = 16'shFF38;
   localparam logic signed [15:0] TEMP_MAX = 16'sh05DC;
   localparam logic signed [15:0] OFFS_MIN = 16'shFF9C;
   localparam logic signed [15:0] OFFS_MAX = 16'sh0064;

   // ==========
   // Reset values.
   localparam logic [11:0] RST_CTRL = 12'h000;
   localparam logic signed [15:0] RST_SUBST = 16'sh0FA0;
   localparam logic signed [15:0] RST_START = 16'shFF38;
   localparam logic signed [15:0] RST_END = 16'sh05DC;
   localparam logic signed [15:0] RST_OFFSET = 16'sh0000;

   // ==========
   // Divider widths.
   localparam int DIV_NW = 27;
   localparam int DIV_DW = 12;

   // Output response while hold is active.
   typedef enum logic [1:0] {HOLD_LOW, HOLD_HIGH, HOLD_FROZEN, HOLD_SUBST} hold_resp_t;
   // Output response while a fault is present.
   typedef enum logic [2:0] {FLT_LOW, FLT_HIGH, FLT_NAMUR_LOW, FLT_NAMUR_HIGH, FLT_FROZEN, FLT_SUBST} fault_resp_t;

endpackage : loop_out_pkg

// File: test/current_loop_output_select_chk.sv
// Port checker for the current-loop output selector.
// Assumes: bound to the top module; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module current_loop_output_select_chk (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic TEMP_VALID,
   input wire logic TEMP_READY,
   input wire logic FAULT,
   input wire logic HOLD_CONTACT_N,
   input wire logic [15:0] LOOP_UA
);
   // ==========
   // Shadow of the control word, written on the same APB edge.
   logic [11:0] ctrl;
   wire [2:0] fr = ctrl[10:8];
   wire [1:0] hr = ctrl[5:4];
   wire hold = !HOLD_CONTACT_N && ctrl[1] && !FAULT;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ctrl <= 12'h000;
      end else if (PSEL && PENABLE && PWRITE && PREADY && PADDR == loop_out_pkg::ADDR_CTRL) begin
         ctrl <= PWDATA[11:0];
      end
   end
   // Fixed levels: bit 1 picks the NAMUR pair, bit 0 the high end.
   function automatic logic [15:0] fix_ua(input logic [1:0] r);
      fix_ua = r[1] ? (r[0] ? loop_out_pkg::UA_NAMUR_HIGH : loop_out_pkg::UA_NAMUR_LOW)
                    : (r[0] ? loop_out_pkg::UA_HIGH : loop_out_pkg::UA_LOW);
   endfunction : fix_ua
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   sequence s_take; TEMP_VALID && TEMP_READY; endsequence
   sequence s_busy; !TEMP_READY ##[1:40] TEMP_READY; endsequence
   property p_take; s_take |=> s_busy; endproperty
   property p_ready; PREADY; endproperty
   property p_err_phase; PSLVERR |-> PSEL && PENABLE; endproperty
   property p_decode; PSEL && PENABLE && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > 8'h24); endproperty
   property p_range; LOOP_UA >= 16'h0E10 && LOOP_UA <= 16'h55F0; endproperty
   property p_flt_fix; (FAULT && fr < 3'h4) [*3] |-> LOOP_UA == fix_ua(fr[1:0]); endproperty
   property p_hold_fix; (hold && hr < 2'h2) [*6] |-> LOOP_UA == fix_ua({1'b0, hr[0]}); endproperty
   property p_hold_frz; (hold && hr == 2'h2) [*6] |-> $stable(LOOP_UA); endproperty
   a_take: assert property (p_take) else $error("sample handshake not refused while busy");
   a_ready: assert property (p_ready) else $error("bus ready dropped");
   a_err_phase: assert property (p_err_phase) else $error("bus error outside access phase");
   a_decode: assert property (p_decode) else $error("bus error decode wrong");
   a_range: assert property (p_range) else $error("loop target out of range");
   a_flt_fix: assert property (p_flt_fix) else $error("fault level wrong");
   a_hold_fix: assert property (p_hold_fix) else $error("hold level wrong");
   a_hold_frz: assert property (p_hold_frz) else $error("held value moved");
endmodule : current_loop_output_select_chk
bind current_loop_output_select current_loop_output_select_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .TEMP_VALID(TEMP_VALID), .TEMP_READY(TEMP_READY), .FAULT(FAULT),
   .HOLD_CONTACT_N(HOLD_CONTACT_N), .LOOP_UA(LOOP_UA));
`default_nettype wire

// File: test/current_loop_output_select_tb_top.sv
// Self-checking bench for the current-loop output selector.
// Assumes: the slave may add wait states; outputs are checked on the falling edge, except bus reads and the reset loop check, on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module current_loop_output_select_tb_top;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic tv = 1'b0, fault = 1'b0, hold_n = 1'b1, pready, pslverr, tr, irq, alarm, rerr;
   logic signed [15:0] td = 16'sh0000;
   logic [15:0] loop_ua;
   int n_errors = 0, checks_done = 0, cyc = 0;
   // Rows: control, start, end, offset, temperature, expected microamps.
   logic [15:0] rows [8][6] = '{'{16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h01F4, 16'h2EE0},
      '{16'h0001, 16'h0000, 16'h03E8, 16'h0000, 16'h00FA, 16'h3E80},
      '{16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'hFF6A, 16'h0FA0},
      '{16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h04B0, 16'h4E20},
      '{16'h0000, 16'h0000, 16'h03E8, 16'h0064, 16'h0190, 16'h2EE0},
      '{16'h0000, 16'h0000, 16'h03E8, 16'hFF6A, 16'h0258, 16'h2EE0},
      '{16'h0001, 16'hFF38, 16'h05DC, 16'h0000, 16'hFF38, 16'h4E20},
      '{16'h0000, 16'h03E8, 16'h0000, 16'h0000, 16'h00FA, 16'h3E80}};
   logic [15:0] hexp [4] = '{16'h0FA0, 16'h4E20, 16'h3E80, 16'h1388};
   logic [15:0] fexp [6] = '{16'h0FA0, 16'h4E20, 16'h0E10, 16'h55F0, 16'h3E80, 16'h1388};
   current_loop_output_select dut (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TEMP_VALID(tv), .TEMP_DATA(td), .TEMP_READY(tr), .FAULT(fault),
      .HOLD_CONTACT_N(hold_n), .LOOP_UA(loop_ua), .IRQ(irq));
   loop_drv_model u_drv (.loop_ua(loop_ua), .alarm(alarm));
   initial begin
      forever #2 clk = ~clk;
   end
   // A hang is cut off well beyond the few hundred cycles the sequence needs.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done = checks_done + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One APB transfer; data and error are taken at the rising edge that sees pready.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   // Offer one sample, then wait for the selector to finish and settle.
   task automatic send(input logic [15:0] t);
      @(posedge clk);
      {tv, td} <= {1'b1, t};
      do @(posedge clk); while (tr !== 1'b1);
      tv <= 1'b0;
      do @(posedge clk); while (tr !== 1'b1);
      wt(2);
   endtask : send
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      chk("reset loop", 32'h0000_0FA0, {16'h0000, loop_ua});
      apb(1'b0, loop_out_pkg::ADDR_START, 32'h0000_0000);
      chk("reset start", 32'hFFFF_FF38, rdat);
      apb(1'b0, 8'h28, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, rerr});
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, loop_out_pkg::ADDR_OFFSET, {{16{rows[i][3][15]}}, rows[i][3]});
         apb(1'b1, loop_out_pkg::ADDR_START, {{16{rows[i][1][15]}}, rows[i][1]});
         apb(1'b1, loop_out_pkg::ADDR_END, {16'h0000, rows[i][2]});
         apb(1'b1, loop_out_pkg::ADDR_CTRL, {16'h0000, rows[i][0]});
         send(rows[i][4]);
         chk("scaled loop", {16'h0000, rows[i][5]}, {16'h0000, loop_ua});
      end
      apb(1'b1, loop_out_pkg::ADDR_SUBST, 32'h0000_7530);
      apb(1'b0, loop_out_pkg::ADDR_SUBST, 32'h0000_0000);
      chk("subst clamp", 32'h0000_55F0, rdat);
      apb(1'b1, loop_out_pkg::ADDR_SUBST, 32'h0000_1388);
      for (int h = 0; h < 4; h++) begin
         apb(1'b1, loop_out_pkg::ADDR_CTRL, 32'h0000_0002 | (h << 4));
         hold_n <= 1'b0;
         wt(6);
         chk("hold loop", {16'h0000, hexp[h]}, {16'h0000, loop_ua});
         @(posedge clk) hold_n <= 1'b1;
         wt(6);
         chk("hold release", 32'h0000_3E80, {16'h0000, loop_ua});
      end
      apb(1'b1, loop_out_pkg::ADDR_CTRL, 32'h0000_0030);
      hold_n <= 1'b0;
      wt(6);
      chk("input inactive", 32'h0000_3E80, {16'h0000, loop_ua});
      @(posedge clk) hold_n <= 1'b1;
      for (int f = 0; f < 6; f++) begin
         apb(1'b1, loop_out_pkg::ADDR_CTRL, f << 8);
         fault <= 1'b1;
         wt(3);
         chk("fault loop", {16'h0000, fexp[f]}, {16'h0000, loop_ua});
         @(posedge clk) fault <= 1'b0;
         wt(3);
      end
      apb(1'b1, loop_out_pkg::ADDR_INT_CLR, 32'h0000_003F);
      apb(1'b1, loop_out_pkg::ADDR_INT_EN, 32'h0000_0008);
      fault <= 1'b1;
      wt(3);
      chk("irq raised", 32'h0000_0001, {31'h0, irq});
      apb(1'b1, loop_out_pkg::ADDR_INT_EN, 32'h0000_0000);
      wt(1);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, loop_out_pkg::ADDR_INT_EN, 32'h0000_0008);
      apb(1'b1, loop_out_pkg::ADDR_INT_CLR, 32'h0000_0008);
      wt(1);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      chk("driver alarm", 32'h0000_0000, {31'h0, alarm});
      finish_test();
   end
endmodule : current_loop_output_select_tb_top
`default_nettype wire

// File: test/loop_drv_model.sv
// Model of the analog loop driver that turns the target value into current.
// Assumes: the target arrives in microamps from the selector.
`timescale 1ns/1ns
`default_nettype none
module loop_drv_model (
   input wire logic [15:0] loop_ua,
   output logic alarm
);
   // A real driver saturates outside 3.6 to 22 mA, so such a target is flagged.
   assign alarm = (loop_ua < 16'h0E10) || (loop_ua > 16'h55F0);
endmodule : loop_drv_model
`default_nettype wire
